// >>> design/pcits_pkg.sv
// shared constants for the target status and local interrupt block
`default_nettype none
package pcits_pkg;
	////////////////////////////////////////////////////////////////////////////
	// register port
	localparam int          ADDR_W       = 8;
	localparam logic [7:0]  OFS_CMD      = 8'h00;
	localparam logic [7:0]  OFS_CFG      = 8'h04;
	localparam logic [7:0]  OFS_BAR0     = 8'h08;
	localparam logic [7:0]  OFS_ROM      = 8'h20;
	localparam logic [7:0]  OFS_STATUS   = 8'h24;
	localparam logic [7:0]  OFS_IRQ_STAT = 8'h28;
	localparam logic [7:0]  OFS_IRQ_MASK = 8'h2C;
	localparam int          NUM_BARS     = 6;
	////////////////////////////////////////////////////////////////////////////
	// field positions
	localparam int CMD_IO_EN_BIT   = 0;
	localparam int CMD_MEM_EN_BIT  = 1;
	localparam int CMD_INT_DIS_BIT = 10;
	localparam int CFG_PAIR01_BIT  = 0;
	localparam int CFG_PAIR12_BIT  = 1;
	localparam int BAR_IO_BIT      = 0;
	localparam int ROM_EN_BIT      = 0;
	localparam int ST_ROM_BIT      = 6;
	localparam int ST_WIDE_BIT     = 7;
	localparam int ST_ACCESS_BIT   = 8;
	localparam int ST_BURST_BIT    = 9;
	localparam int ST_XFR_BIT      = 10;
	localparam int ST_DAC_BIT      = 11;
	localparam int EV_CLAIM_BIT    = 0;
	localparam int EV_BURST_BIT    = 1;
	localparam int EV_END_BIT      = 2;
	localparam int EV_W            = 3;
	localparam int STATUS_W        = 12;
	////////////////////////////////////////////////////////////////////////////
	// reset values
	localparam logic [31:0]         CMD_RST    = 32'h0000_0000;
	localparam logic [31:0]         BAR_RST    = 32'h0000_0000;
	localparam logic [1:0]          CFG_RST    = 2'h0;
	localparam logic [EV_W-1:0]     EV_RST     = 3'h0;
	localparam logic [STATUS_W-1:0] STATUS_RST = 12'h000;
	////////////////////////////////////////////////////////////////////////////
	// bus command codes
	localparam logic [3:0] PCMD_IO_RD  = 4'h2;
	localparam logic [3:0] PCMD_IO_WR  = 4'h3;
	localparam logic [3:0] PCMD_MEM_RD = 4'h6;
	localparam logic [3:0] PCMD_MEM_WR = 4'h7;
	localparam logic [3:0] PCMD_MRM    = 4'hC;
	localparam logic [3:0] PCMD_DAC    = 4'hD;
	localparam logic [3:0] PCMD_MRL    = 4'hE;
	localparam logic [3:0] PCMD_MWI    = 4'hF;
	typedef enum logic [2:0] {ST_IDLE, ST_DAC_HI, ST_DECODE, ST_ACTIVE, ST_WAIT_IDLE} pcits_state_t;
endpackage : pcits_pkg
`default_nettype wire

// >>> design/pcits_target_status.sv
// target transaction status bus and local interrupt forwarding
`default_nettype none
module pcits_target_status
	import pcits_pkg::*;
#(
	parameter int WIDE_EN       = 1,
	parameter int BAR_APER_BITS = 12,
	parameter int ROM_APER_BITS = 16
) (
	input  wire logic                        i_core_clk,
	input  wire logic                        i_rstn,
	input  wire logic [31:0]                 i_ad,
	input  wire logic [3:0]                  i_cbe,
	input  wire logic                        i_framen,
	input  wire logic                        i_irdyn,
	input  wire logic                        i_trdyn,
	input  wire logic                        i_stopn,
	input  wire logic                        i_req64n,
	input  wire logic                        i_lirqn,
	output logic                             o_inta_out,
	output logic                             o_inta_oe,
	output logic [pcits_pkg::STATUS_W-1:0]   o_local_target_status_bus,
	input  wire logic [pcits_pkg::ADDR_W-1:0] i_reg_addr,
	input  wire logic [31:0]                 i_reg_wdata,
	input  wire logic                        i_reg_wr,
	input  wire logic                        i_reg_rd,
	output logic [31:0]                      o_reg_rdata,
	output logic                             o_irq
);
	import pcits_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// software-visible registers
	logic [31:0]           cmd_r;
	logic [1:0]            cfg_r;
	logic [31:0]           bar_r [NUM_BARS];
	logic [31:0]           rom_r;
	logic [EV_W-1:0]       ev_stat_r;
	logic [EV_W-1:0]       ev_mask_r;
	logic [EV_W-1:0]       ev_pulse;
	logic [31:0]           rdata_nxt;

	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			cmd_r <= CMD_RST;
			cfg_r <= CFG_RST;
			rom_r <= BAR_RST;
		end else if (i_reg_wr) begin
			// the disable bit reaches the interrupt pin one edge after the write
			if (i_reg_addr == OFS_CMD) begin
				cmd_r <= i_reg_wdata;
			end
			if (i_reg_addr == OFS_CFG) begin
				cfg_r <= i_reg_wdata[1:0];
			end
			if (i_reg_addr == OFS_ROM) begin
				rom_r <= i_reg_wdata;
			end
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			for (int k = 0; k < NUM_BARS; k++)
				bar_r[k] <= BAR_RST;
		end else begin
			for (int k = 0; k < NUM_BARS; k++) begin
				if (i_reg_wr && i_reg_addr == OFS_BAR0 + ADDR_W'(k * 4)) begin
					bar_r[k] <= i_reg_wdata;
				end
			end
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			ev_mask_r <= EV_RST;
		end else if (i_reg_wr && i_reg_addr == OFS_IRQ_MASK) begin
			ev_mask_r <= i_reg_wdata[EV_W-1:0];
		end
	end

	// a new event wins over a write-one-to-clear in the same cycle
	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			ev_stat_r <= EV_RST;
		end else if (i_reg_wr && i_reg_addr == OFS_IRQ_STAT) begin
			ev_stat_r <= (ev_stat_r & ~i_reg_wdata[EV_W-1:0]) | ev_pulse;
		end else begin
			ev_stat_r <= ev_stat_r | ev_pulse;
		end
	end

	always_comb begin
		rdata_nxt = 32'h0000_0000;
		// unmapped offsets fall through and read as zero
		for (int k = 0; k < NUM_BARS; k++) begin
			if (i_reg_addr == OFS_BAR0 + ADDR_W'(k * 4)) begin
				rdata_nxt = bar_r[k];
			end
		end
		case (i_reg_addr)
			OFS_CMD:      rdata_nxt = cmd_r;
			OFS_CFG:      rdata_nxt = {30'h0000_0000, cfg_r};
			OFS_ROM:      rdata_nxt = rom_r;
			OFS_STATUS:   rdata_nxt = {20'h0_0000, o_local_target_status_bus};
			OFS_IRQ_STAT: rdata_nxt = {29'h0000_0000, ev_stat_r};
			OFS_IRQ_MASK: rdata_nxt = {29'h0000_0000, ev_mask_r};
			default:      ;
		endcase
	end

	// read data stand only in the cycle after the strobe
	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_reg_rdata <= 32'h0000_0000;
		end else if (i_reg_rd) begin
			o_reg_rdata <= rdata_nxt;
		end else begin
			o_reg_rdata <= 32'h0000_0000;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		// one edge behind the sticky bits; harmless for a level line
		if (!i_rstn) begin
			o_irq <= 1'b0;
		end else begin
			o_irq <= |(ev_stat_r & ev_mask_r);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// local interrupt onto pin A (open drain: only ever pulls low)
	// registered so the pin never glitches; costs one cycle of lag
	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_inta_oe  <= 1'b0;
			o_inta_out <= 1'b0;
		end else begin
			o_inta_oe  <= ~i_lirqn & ~cmd_r[CMD_INT_DIS_BIT];
			o_inta_out <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// address phase capture and transaction tracking
	// only an idle bus after a claimed or refused transaction re-arms capture
	pcits_state_t state_r;
	logic         prev_framen_r;
	logic [63:0]  addr_r;
	logic [3:0]   pcmd_r;
	logic         dac_r;
	logic         wide_r;
	logic         first_phase_r;
	logic         burst_r;
	logic [6:0]   hit_r;
	logic [5:0]   bar_match;
	logic [5:0]   bar_hit;
	logic         rom_match;
	logic         io_cmd;
	logic         mem_cmd;
	logic         pair01;
	logic         pair12;
	logic         addr_phase;
	logic         bus_idle;
	logic         phase_done;
	logic         active;

	assign addr_phase = prev_framen_r & ~i_framen & i_irdyn;
	assign bus_idle   = i_framen & i_irdyn;
	assign active     = (state_r == ST_ACTIVE);
	assign phase_done = active & ~i_irdyn & ~i_trdyn;
	assign io_cmd     = cmd_r[CMD_IO_EN_BIT] & (pcmd_r == PCMD_IO_RD || pcmd_r == PCMD_IO_WR);
	assign mem_cmd    = cmd_r[CMD_MEM_EN_BIT] & (pcmd_r == PCMD_MEM_RD || pcmd_r == PCMD_MEM_WR
		|| pcmd_r == PCMD_MRM || pcmd_r == PCMD_MRL || pcmd_r == PCMD_MWI);
	// both pairings at once would share window 1; the lower pair takes it
	assign pair01     = cfg_r[CFG_PAIR01_BIT];
	assign pair12     = cfg_r[CFG_PAIR12_BIT] & ~pair01;

	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn)
			prev_framen_r <= 1'b1;
		else
			prev_framen_r <= i_framen;
	end

	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			state_r <= ST_IDLE;
		end else begin
			case (state_r)
				ST_IDLE: begin
					if (addr_phase)
						state_r <= (i_cbe == PCMD_DAC) ? ST_DAC_HI : ST_DECODE;
				end
				ST_DAC_HI:    state_r <= ST_DECODE;
				ST_DECODE:    state_r <= (|bar_hit | rom_match) ? ST_ACTIVE : ST_WAIT_IDLE;
				ST_ACTIVE:    if (bus_idle) state_r <= ST_IDLE;
				ST_WAIT_IDLE: if (bus_idle) state_r <= ST_IDLE;
				default:      state_r <= ST_IDLE;
			endcase
		end
	end

	// a dual address cycle sends the low half first, then the real command
	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			addr_r <= 64'h0000_0000_0000_0000;
			pcmd_r <= 4'h0;
			dac_r  <= 1'b0;
			wide_r <= 1'b0;
		end else if (state_r == ST_IDLE && addr_phase) begin
			addr_r <= {32'h0000_0000, i_ad};
			pcmd_r <= i_cbe;
			dac_r  <= (i_cbe == PCMD_DAC);
			wide_r <= (WIDE_EN != 0) & ~i_req64n;
		end else if (state_r == ST_DAC_HI) begin
			addr_r[63:32] <= i_ad;
			pcmd_r        <= i_cbe;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// window compare, one comparator per window
	// pairing is read live from the config word, so software must not
	// change it while a transaction is being decoded
	genvar gi;
	generate
		for (gi = 0; gi < NUM_BARS; gi++) begin : g_win
			logic        is64;
			logic        upper_half;
			logic [31:0] base_hi;
			if (gi < NUM_BARS - 1) begin : g_hi
				assign base_hi = bar_r[gi + 1];
			end else begin : g_nohi
				assign base_hi = 32'h0000_0000;
			end
			assign is64       = (gi == 0) ? pair01 : ((gi == 1) ? pair12 : 1'b0);
			assign upper_half = (gi == 1) ? pair01 : ((gi == 2) ? pair12 : 1'b0);
			pcits_win_match #(
				.APER_BITS (BAR_APER_BITS)
			) u_bar (
				.i_addr    (addr_r),
				.i_base_lo (bar_r[gi]),
				.i_base_hi (base_hi),
				.i_is64    (is64),
				.i_io_win  (bar_r[gi][BAR_IO_BIT]),
				.i_io_cmd  (io_cmd),
				.i_mem_cmd (mem_cmd),
				.i_enable  (~upper_half),
				.o_match   (bar_match[gi])
			);
		end
	endgenerate

	pcits_win_match #(
		.APER_BITS (ROM_APER_BITS)
	) u_rom (
		.i_addr    (addr_r),
		.i_base_lo (rom_r),
		.i_base_hi (32'h0000_0000),
		.i_is64    (1'b0),
		.i_io_win  (1'b0),
		.i_io_cmd  (1'b0),
		.i_mem_cmd (mem_cmd),
		.i_enable  (rom_r[ROM_EN_BIT]),
		.o_match   (rom_match)
	);

	assign bar_hit[0] = bar_match[0];
	assign bar_hit[1] = bar_match[1] | (pair01 & bar_match[0]);
	assign bar_hit[2] = bar_match[2] | (pair12 & bar_match[1]);
	assign bar_hit[5:3] = bar_match[5:3];

	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn)
			hit_r <= 7'h00;
		else if (state_r == ST_DECODE)
			hit_r <= {rom_match, bar_hit};
	end

	////////////////////////////////////////////////////////////////////////////
	// burst detection over the first data phase
	// stop also ends the first phase, so a retried single never reads as burst
	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			first_phase_r <= 1'b0;
			burst_r       <= 1'b0;
		end else if (state_r == ST_DECODE) begin
			first_phase_r <= 1'b1;
			burst_r       <= 1'b0;
		end else if (active && first_phase_r && !i_irdyn) begin
			burst_r <= burst_r | ~i_framen;
			if (!i_trdyn || !i_stopn)
				first_phase_r <= 1'b0;
		end else if (!active) begin
			first_phase_r <= 1'b0;
			burst_r       <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// status bus, rebuilt every edge from the transaction state
	// bits show two edges after the address phase (three for a dual address cycle) and drop one edge after idle;
	// local logic that needs the hit sooner must decode the bus itself
	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_local_target_status_bus <= STATUS_RST;
		end else if (!active) begin
			o_local_target_status_bus <= STATUS_RST;
		end else begin
			o_local_target_status_bus[5:0]           <= hit_r[5:0];
			o_local_target_status_bus[ST_ROM_BIT]    <= hit_r[6];
			o_local_target_status_bus[ST_WIDE_BIT]   <= wide_r;
			o_local_target_status_bus[ST_ACCESS_BIT] <= 1'b1;
			o_local_target_status_bus[ST_BURST_BIT]  <= burst_r | (first_phase_r
				& ~i_irdyn & ~i_framen);
			o_local_target_status_bus[ST_XFR_BIT]    <= phase_done;
			o_local_target_status_bus[ST_DAC_BIT]    <= dac_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// interrupt events
	// each event is a one-cycle pulse; the sticky status keeps it for software
	assign ev_pulse[EV_CLAIM_BIT] = (state_r == ST_DECODE) & (|bar_hit | rom_match);
	assign ev_pulse[EV_BURST_BIT] = active & first_phase_r & ~i_irdyn & ~i_framen & ~burst_r;
	assign ev_pulse[EV_END_BIT]   = active & bus_idle;

endmodule : pcits_target_status
`default_nettype wire

// >>> design/pcits_win_match.sv
// address window comparator for one base address window
`default_nettype none
module pcits_win_match #(
	parameter int APER_BITS = 12
) (
	input  wire logic [63:0] i_addr,
	input  wire logic [31:0] i_base_lo,
	input  wire logic [31:0] i_base_hi,
	input  wire logic        i_is64,
	input  wire logic        i_io_win,
	input  wire logic        i_io_cmd,
	input  wire logic        i_mem_cmd,
	input  wire logic        i_enable,
	output logic             o_match
);
	logic lo_eq;
	logic hi_eq;
	logic kind_ok;

	// low aperture bits carry window attributes, never part of the compare
	assign lo_eq   = (i_addr[31:APER_BITS] == i_base_lo[31:APER_BITS]);
	// a 32-bit window only answers addresses below 4 GiB
	assign hi_eq   = i_is64 ? (i_addr[63:32] == i_base_hi) : (i_addr[63:32] == 32'h0000_0000);
	assign kind_ok = i_io_win ? i_io_cmd : i_mem_cmd;
	assign o_match = i_enable & kind_ok & lo_eq & hi_eq;
endmodule : pcits_win_match
`default_nettype wire

// >>> tb/pcits_local_model.sv
// local peripheral model: raises requests, collects status bits and transfer pulses
`default_nettype none
module pcits_local_model (
	input  wire logic        i_core_clk,
	input  wire logic        i_rstn,
	input  wire logic [11:0] i_status,
	input  wire logic        i_clr,
	input  wire logic        i_raise,
	input  wire logic        i_slow,
	output logic             o_lirqn,
	output logic [11:0]      o_seen,
	output logic [7:0]       o_xfr_cnt
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] dly_r;
	// slow mode answers three cycles late, as a busy peripheral would
	assign o_lirqn = !(i_slow ? dly_r[3] : dly_r[0]);
	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn)
			dly_r <= 4'h0;
		else
			dly_r <= {dly_r[2:0], i_raise};
	end
	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_seen    <= 12'h000;
			o_xfr_cnt <= 8'h00;
		end else if (i_clr) begin
			o_seen    <= 12'h000;
			o_xfr_cnt <= 8'h00;
		end else begin
			o_seen    <= o_seen | i_status;
			o_xfr_cnt <= o_xfr_cnt + {7'h00, i_status[10]};
		end
	end
endmodule : pcits_local_model
`default_nettype wire

// >>> tb/pcits_target_status_assertions.sv
// concurrent checks on the target status block ports
`default_nettype none
module pcits_target_status_checker
	import pcits_pkg::*;
#(
	parameter int WIDE_EN = 1
) (
	input wire logic                           i_core_clk,
	input wire logic                           i_rstn,
	input wire logic                           i_framen,
	input wire logic                           i_irdyn,
	input wire logic                           i_trdyn,
	input wire logic                           i_lirqn,
	input wire logic                           o_inta_out,
	input wire logic                           o_inta_oe,
	input wire logic [pcits_pkg::STATUS_W-1:0] o_local_target_status_bus,
	input wire logic [pcits_pkg::ADDR_W-1:0]   i_reg_addr,
	input wire logic [31:0]                    i_reg_wdata,
	input wire logic                           i_reg_wr,
	input wire logic                           i_reg_rd,
	input wire logic [31:0]                    o_reg_rdata,
	input wire logic                           o_irq
);
	logic [11:0] st;
	logic        dis_r;
	logic [1:0]  cfg_r;
	logic [2:0]  mask_r;
	assign st = o_local_target_status_bus;
	////////////////////////////////////////////////////////////////////////////
	// shadow copies: the checker only sees writes on the register port
	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			dis_r  <= 1'b0;
			cfg_r  <= 2'h0;
			mask_r <= 3'h0;
		end else if (i_reg_wr) begin
			if (i_reg_addr == OFS_CMD)
				dis_r <= i_reg_wdata[CMD_INT_DIS_BIT];
			if (i_reg_addr == OFS_CFG)
				cfg_r <= i_reg_wdata[1:0];
			if (i_reg_addr == OFS_IRQ_MASK)
				mask_r <= i_reg_wdata[2:0];
		end
	end
	////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (!i_rstn);
	inta_follow_a: assert property (o_inta_oe == $past(!i_lirqn && !dis_r))
		else $error("interrupt pin enable does not follow local request");
	inta_low_a: assert property (!o_inta_out)
		else $error("interrupt pin driven high");
	rd_idle_a: assert property (!$past(i_reg_rd) |-> o_reg_rdata == 32'h0)
		else $error("read data not zero outside read answer");
	st_read_a: assert property (i_reg_rd && i_reg_addr == OFS_STATUS |=>
		o_reg_rdata == {20'h0, $past(st)})
		else $error("status register read differs from status bus");
	irq_mask_a: assert property (o_irq |-> ($past(mask_r) != 3'h0 || $past(mask_r, 2) != 3'h0))
		else $error("interrupt raised with all events masked");
	xfr_pulse_a: assert property (st[ST_XFR_BIT] |-> $past(!i_irdyn && !i_trdyn))
		else $error("transfer flag without completed data phase");
	burst_rise_a: assert property ($rose(st[ST_BURST_BIT]) |-> $past(!i_framen && !i_irdyn))
		else $error("burst flag without frame and ready together");
	idle_clear_a: assert property (!st[ST_ACCESS_BIT] |-> st == 12'h000)
		else $error("status bits set outside a target access");
	end_clear_a: assert property ($fell(st[ST_ACCESS_BIT]) |-> $past(i_framen && i_irdyn, 2))
		else $error("access flag dropped before bus idle");
	pair_low_a: assert property (cfg_r[0] && st[1] |-> st[0])
		else $error("upper half of window pair hit alone");
	pair_mid_a: assert property (cfg_r == 2'h2 && st[2] |-> st[1])
		else $error("upper half of second window pair hit alone");
	reset_out_a: assert property ($rose(i_rstn) |-> st == 12'h000 && !o_irq && !o_inta_oe)
		else $error("outputs not cleared after reset");
	narrow_wide_a: assert property (st[ST_WIDE_BIT] |-> WIDE_EN != 0 && st[ST_ACCESS_BIT])
		else $error("wide flag set in narrow variant");
	burst_c: cover property ($rose(st[ST_BURST_BIT]));
	dac_c: cover property ($rose(st[ST_DAC_BIT]));
	inta_c: cover property ($rose(o_inta_oe));
	irq_c: cover property ($fell(o_irq));
endmodule : pcits_target_status_checker

bind pcits_target_status pcits_target_status_checker #(.WIDE_EN(WIDE_EN)) u_chk (
	.i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_framen(i_framen), .i_irdyn(i_irdyn),
	.i_trdyn(i_trdyn), .i_lirqn(i_lirqn), .o_inta_out(o_inta_out), .o_inta_oe(o_inta_oe),
	.o_local_target_status_bus(o_local_target_status_bus), .i_reg_addr(i_reg_addr),
	.i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
	.o_reg_rdata(o_reg_rdata), .o_irq(o_irq));
`default_nettype wire

// >>> tb/pcits_target_status_tb.sv
// self-checking bench for the target status block
`default_nettype none
module pcits_target_status_tb;
	import pcits_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0, rstn = 1'b0, framen = 1'b1, irdyn = 1'b1, trdyn = 1'b1, req64n = 1'b1;
	logic wr = 1'b0, rd = 1'b0, clr = 1'b0, raise = 1'b0, slow = 1'b0, lirqn, oe, irq, inta_out;
	logic [31:0] ad = 32'h0, wdata = 32'h0, rdata;
	logic [3:0]  cbe = 4'h0;
	logic [7:0]  addr = 8'h00, cnt;
	logic [11:0] st, seen;
	logic [3:0]  mcmd[5] = '{PCMD_MEM_RD, PCMD_MEM_WR, PCMD_MRM, PCMD_MRL, PCMD_MWI};
	logic [7:0]  offs[8] = '{OFS_CMD, OFS_CFG, OFS_BAR0, OFS_ROM, OFS_STATUS, OFS_IRQ_STAT,
		OFS_IRQ_MASK, 8'h30};
	int miscompares = 0, check_count = 0, cycles = 0;
	always #20 clk = ~clk;
	pcits_target_status dut (.i_core_clk(clk), .i_rstn(rstn), .i_ad(ad), .i_cbe(cbe),
		.i_framen(framen), .i_irdyn(irdyn), .i_trdyn(trdyn), .i_stopn(1'b1),
		.i_req64n(req64n), .i_lirqn(lirqn), .o_inta_out(inta_out), .o_inta_oe(oe),
		.o_local_target_status_bus(st), .i_reg_addr(addr), .i_reg_wdata(wdata),
		.i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata), .o_irq(irq));
	pcits_local_model u_local (.i_core_clk(clk), .i_rstn(rstn), .i_status(st), .i_clr(clr),
		.i_raise(raise), .i_slow(slow), .o_lirqn(lirqn), .o_seen(seen), .o_xfr_cnt(cnt));
	////////////////////////////////////////////////////////////////////////////
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : print_verdict
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : reg_wr
	task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk(rdata, exp);
	endtask : reg_rd
	function automatic logic [11:0] exp_st(input logic [6:0] hit, input int n, input logic w,
			input logic dac);
		exp_st = {dac, 1'b1, n > 1, 1'b1, w, hit};
	endfunction : exp_st
	// one target transaction; upper address non-zero means a dual address cycle
	task automatic txn(input logic [63:0] a, input logic [3:0] c, input int n, input logic w,
			input logic [11:0] exp);
		@(posedge clk);
		clr <= 1'b1;
		framen <= 1'b0;
		req64n <= !w;
		ad <= a[31:0];
		cbe <= (a[63:32] != 32'h0) ? PCMD_DAC : c;
		if (a[63:32] != 32'h0) begin
			@(posedge clk);
			ad <= a[63:32];
			cbe <= c;
		end
		@(posedge clk);
		clr <= 1'b0;
		irdyn <= 1'b0;
		framen <= (n == 1);
		ad <= $urandom;
		@(posedge clk);
		for (int i = 0; i < n; i++) begin
			@(posedge clk);
			trdyn <= 1'b0;
			framen <= (i == n - 1);
		end
		@(posedge clk);
		{framen, irdyn, trdyn, req64n} <= 4'hF;
		repeat (3) @(posedge clk);
		#1 chk({20'h0, seen}, {20'h0, exp});
		chk({24'h0, cnt}, exp[8] ? 32'(n) : 32'h0);
		chk({20'h0, st}, 32'h0);
	endtask : txn
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			print_verdict();
		end
	end
	////////////////////////////////////////////////////////////////////////////
	initial begin
		logic [31:0] a;
		int w, n;
		logic r;
		void'($urandom(32'h4D44));
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
		for (int i = 0; i < 8; i++)
			reg_rd(offs[i], 32'h0);
		reg_wr(OFS_CMD, 32'h3);
		for (int k = 0; k < 5; k++)
			reg_wr(OFS_BAR0 + 8'(4 * k), {4'(k + 1), 28'h0});
		reg_wr(OFS_BAR0 + 8'h14, 32'h0000_6001);
		reg_wr(OFS_ROM, 32'hE000_0001);
		reg_wr(OFS_IRQ_MASK, 32'h7);
		reg_wr(OFS_STATUS, 32'hFFF);
		reg_rd(OFS_STATUS, 32'h0);
		for (int j = 0; j < 16; j++) begin
			w = $urandom_range(6);
			n = $urandom_range(4, 1);
			r = 1'($urandom_range(1));
			a = {20'h0, 10'($urandom), 2'h0};
			a = (w < 5) ? a | {4'(w + 1), 28'h0} : (w == 5) ? a | 32'h6000 : a | 32'hE000_0000;
			txn({32'h0, a}, (w == 5) ? (j[0] ? PCMD_IO_WR : PCMD_IO_RD) : mcmd[j % 5], n, r,
				exp_st(7'(1 << w), n, r, 1'b0));
			reg_rd(OFS_IRQ_STAT, (n > 1) ? 32'h7 : 32'h5);
			chk({31'h0, irq}, 32'h1);
			reg_wr(OFS_IRQ_STAT, 32'h7);
		end
		reg_wr(OFS_CMD, 32'h0);
		txn({32'h0, 32'h1000_0040}, PCMD_MEM_RD, 2, 1'b0, 12'h000);
		reg_wr(OFS_CMD, 32'h3);
		reg_wr(OFS_CFG, 32'h1);
		reg_wr(OFS_BAR0 + 8'h04, 32'h0000_0001);
		txn({32'h1, 32'h1000_0040}, PCMD_MEM_WR, 1, 1'b1, exp_st(7'h03, 1, 1'b1, 1'b1));
		txn({32'h0, 32'h2000_0000}, PCMD_MEM_RD, 1, 1'b0, 12'h000);
		reg_wr(OFS_CFG, 32'h2);
		reg_wr(OFS_BAR0 + 8'h04, 32'h2000_0000);
		reg_wr(OFS_BAR0 + 8'h08, 32'h0);
		txn({32'h0, 32'h2000_0100}, PCMD_MEM_RD, 3, 1'b0, exp_st(7'h06, 3, 1'b0, 1'b0));
		reg_wr(OFS_IRQ_MASK, 32'h0);
		repeat (2) @(posedge clk);
		#1 chk({31'h0, irq}, 32'h0);
		reg_wr(OFS_IRQ_MASK, 32'h7);
		repeat (2) @(posedge clk);
		#1 chk({31'h0, irq}, 32'h1);
		reg_wr(OFS_IRQ_STAT, 32'h7);
		repeat (2) @(posedge clk);
		#1 chk({31'h0, irq}, 32'h0);
		for (int s = 0; s < 2; s++) begin
			slow <= 1'(s);
			raise <= 1'b1;
			repeat (6) @(posedge clk);
			#1 chk({31'h0, oe}, 32'h1);
			chk({31'h0, inta_out}, 32'h0);
			reg_wr(OFS_CMD, 32'h403);
			repeat (2) @(posedge clk);
			#1 chk({31'h0, oe}, 32'h0);
			reg_wr(OFS_CMD, 32'h3);
			raise <= 1'b0;
			repeat (6) @(posedge clk);
			#1 chk({31'h0, oe}, 32'h0);
		end
		print_verdict();
	end
endmodule : pcits_target_status_tb
`default_nettype wire
